// ### hdl/ccl_cfg.svh
// Offsets, field positions and reset values of the comparator control block.
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CCL_ADR_CTRL_STATUS 4'h0
`define CCL_ADR_CONV_B 4'h4
`define CCL_ADR_DIN_DIS 4'h8
`define CCL_ADR_CONV_SIDE 4'hC
// ----------------------------------------------------------------------------
// Control and status register bits
// ----------------------------------------------------------------------------
`define CCL_CS_DISABLE 7
`define CCL_CS_IREF 6
`define CCL_CS_OUT 5
`define CCL_CS_FLAG 4
`define CCL_CS_IRQ_EN 3
`define CCL_CS_CAPTURE 2
`define CCL_CS_MODE_HI 1
`define CCL_CS_MODE_LO 0
// ----------------------------------------------------------------------------
// Converter control B, side and pin disable register fields
// ----------------------------------------------------------------------------
`define CCL_CB_MUX_EN 6
`define CCL_CB_DIV_HI 5
`define CCL_CB_DIV_LO 4
`define CCL_CB_RSVD 3
`define CCL_SIDE_CONV_EN 7
`define CCL_SIDE_REFSEL_HI 6
`define CCL_SIDE_REFSEL_LO 5
`define CCL_SIDE_CHAN_HI 4
`define CCL_SIDE_CHAN_LO 0
`define CCL_DIS_POS 7
`define CCL_DIS_NEG 6
// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define CCL_CHAN_LAST 5'h0_00A
`define CCL_REFSEL_INTERNAL 2'h3
`define CCL_RESET_BYTE 8'h00
`define CCL_BYTE_W 8
`endif

// ### hdl/ccl_pkg.sv
// Types shared by the comparator control block.
package ccl_pkg;
    // Event selection of the interrupt-mode field.
    typedef enum logic [1:0] {
        CCL_MODE_TOGGLE = 2'h0,
        CCL_MODE_RSVD = 2'h1,
        CCL_MODE_FALL = 2'h2,
        CCL_MODE_RISE = 2'h3
    } ccl_mode_e;

    // Bus slave answer states, one-hot.
    typedef enum logic [1:0] {
        CCL_BUS_IDLE = 2'b01,
        CCL_BUS_ACK = 2'b10
    } ccl_bus_e;
endpackage : ccl_pkg

// ### hdl/ccl_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/100ps
module ccl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);
    // ------------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------------
    logic [WIDTH-1:0] meta;

    // The first stage is read only by the second, so metastability stays here.
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            meta <= '0;
            SYNC_OUT <= '0;
        end else begin
            meta <= ASYNC_IN;
            SYNC_OUT <= meta;
        end
    end
endmodule : ccl_sync

// ### hdl/ccl_top.sv
// Comparator control logic: input selection, sync, event flag, Wishbone regs.
// Behaviour
// - Mux enable and converter off selects channel
// - Otherwise dedicated positive pin feeds positive input
// - Channel codes 0..10 valid; others unusable
// - Internal reference select chooses negative input source
// - Division field picks full, half, quarter, eighth
// - Disable bit powers comparator off anytime
// - Comparator result synchronised, read-only status bit
// - Flag set on selected synchronised event
// - Flag cleared by vector or writing one
// - Request needs flag, enable and global enable
// - Mode field: toggle, falling, rising; 01 reserved
// - Capture enable routes output to capture
// - Pin disable bits kill buffer, read zero
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ccl_cfg.svh"
module ccl_top
    import ccl_pkg::*;
#(
    parameter int CHAN_W = 5
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // Wishbone classic slave.
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Analog core and pins.
    input wire logic CMP_RAW_IN,
    input wire logic POS_PIN_DIG_IN,
    input wire logic NEG_PIN_DIG_IN,
    input wire logic GLOBAL_IRQ_EN_IN,
    input wire logic IRQ_VECTOR_IN,
    output logic CMP_POWER_OFF_OUT,
    output logic POS_FROM_MUX_OUT,
    output logic [CHAN_W-1:0] POS_CHANNEL_OUT,
    output logic NEG_FROM_IREF_OUT,
    output logic [1:0] IREF_DIVIDE_OUT,
    output logic IREF_VALID_OUT,
    output logic CAPTURE_SRC_OUT,
    output logic CAPTURE_ROUTE_OUT,
    output logic POS_BUF_OFF_OUT,
    output logic NEG_BUF_OFF_OUT,
    output logic POS_PIN_READ_OUT,
    output logic NEG_PIN_READ_OUT,
    output logic IRQ_OUT
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        ccl_bus_e bus;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] conv_b;
        logic [7:0] din_dis;
        logic conv_en;
        logic [1:0] ref_sel;
        logic [CHAN_W-1:0] chan;
        logic cmp_prev;
        logic flag;
    } ccl_state_s;

    ccl_state_s cur;
    ccl_state_s next_st;
    logic [2:0] sync_out;
    logic cmp_sync;
    logic pos_sync;
    logic neg_sync;
    logic ev_toggle;
    logic ev_rise;
    logic ev_fall;
    logic ev_hit;
    logic wr_ok;
    logic acc;
    logic [7:0] wbyte;
    logic [7:0] side_rd;
    ccl_mode_e mode;

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    // Comparator and both pin buffers are asynchronous; one bank covers them.
    ccl_sync #(
        .WIDTH(3)
    ) u_sync (
        .SYS_CLK_IN(SYS_CLK_IN),
        .RST_IN(RST_IN),
        .ASYNC_IN({NEG_PIN_DIG_IN, POS_PIN_DIG_IN, CMP_RAW_IN}),
        .SYNC_OUT(sync_out)
    );

    // A powered-off comparator is read as low so stale levels raise no event.
    assign cmp_sync = sync_out[0] & ~cur.ctrl[`CCL_CS_DISABLE];
    assign pos_sync = sync_out[1];
    assign neg_sync = sync_out[2];

    // ------------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------------
    // Compare against last cycle's synced value.
    assign ev_toggle = cmp_sync ^ cur.cmp_prev;
    assign ev_rise = cmp_sync & ~cur.cmp_prev;
    assign ev_fall = ~cmp_sync & cur.cmp_prev;
    assign mode = ccl_mode_e'(cur.ctrl[`CCL_CS_MODE_HI:`CCL_CS_MODE_LO]);

    // The reserved mode raises nothing.
    always_comb begin
        case (mode)
            CCL_MODE_TOGGLE: ev_hit = ev_toggle;
            CCL_MODE_FALL: ev_hit = ev_fall;
            CCL_MODE_RISE: ev_hit = ev_rise;
            default: ev_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Only the low byte lane carries register data; other lanes are ignored.
    assign acc = WB_CYC_IN & WB_STB_IN & (cur.bus == CCL_BUS_IDLE);
    assign wr_ok = acc & WB_WE_IN & WB_SEL_IN[0];
    assign wbyte = WB_DAT_IN[7:0];
    assign side_rd = {cur.conv_en, cur.ref_sel, cur.chan};

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = cur;
        next_st.cmp_prev = cmp_sync;
        // Answer takes one cycle; ack drops the cycle after it is given.
        case (cur.bus)
            CCL_BUS_IDLE: begin
                if (acc) begin
                    next_st.bus = CCL_BUS_ACK;
                end
            end
            CCL_BUS_ACK: begin
                next_st.bus = CCL_BUS_IDLE;
            end
            default: begin
                next_st.bus = CCL_BUS_IDLE;
            end
        endcase
        // Read data is latched with the request; unmapped addresses read zero.
        if (acc && !WB_WE_IN) begin
            case (WB_ADR_IN)
                `CCL_ADR_CTRL_STATUS: begin
                    next_st.rdata = {24'h0000_00, cur.ctrl[7:6], cmp_sync, cur.flag,
                        cur.ctrl[3:0]};
                end
                `CCL_ADR_CONV_B: next_st.rdata = {24'h0000_00, cur.conv_b};
                `CCL_ADR_DIN_DIS: next_st.rdata = {24'h0000_00, cur.din_dis};
                `CCL_ADR_CONV_SIDE: next_st.rdata = {24'h0000_00, side_rd};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Register writes; the output bit stays read only.
        if (wr_ok) begin
            case (WB_ADR_IN)
                `CCL_ADR_CTRL_STATUS: begin
                    // Disable, reference select and mode are taken any time.
                    next_st.ctrl = {wbyte[7:6], 1'b0, 1'b0, wbyte[3:0]};
                end
                `CCL_ADR_CONV_B: begin
                    next_st.conv_b = wbyte;
                    next_st.conv_b[`CCL_CB_RSVD] = 1'b0;
                end
                `CCL_ADR_DIN_DIS: next_st.din_dis = wbyte;
                `CCL_ADR_CONV_SIDE: begin
                    next_st.conv_en = wbyte[`CCL_SIDE_CONV_EN];
                    next_st.ref_sel = wbyte[`CCL_SIDE_REFSEL_HI:`CCL_SIDE_REFSEL_LO];
                    next_st.chan = wbyte[`CCL_SIDE_CHAN_HI:`CCL_SIDE_CHAN_LO];
                end
                default: begin
                    next_st.ctrl = cur.ctrl;
                end
            endcase
        end
        // Flag clear by vector or write-one; a new event in the same cycle wins.
        if (IRQ_VECTOR_IN) begin
            next_st.flag = 1'b0;
        end
        if (wr_ok && WB_ADR_IN == `CCL_ADR_CTRL_STATUS && wbyte[`CCL_CS_FLAG]) begin
            next_st.flag = 1'b0;
        end
        if (ev_hit) begin
            next_st.flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cur.bus <= CCL_BUS_IDLE;
            cur.rdata <= 32'h0000_0000;
            cur.ctrl <= `CCL_RESET_BYTE;
            cur.conv_b <= `CCL_RESET_BYTE;
            cur.din_dis <= `CCL_RESET_BYTE;
            cur.conv_en <= 1'b0;
            cur.ref_sel <= 2'h0;
            cur.chan <= '0;
            cur.cmp_prev <= 1'b0;
            cur.flag <= 1'b0;
        end else begin
            cur <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign WB_ACK_OUT = (cur.bus == CCL_BUS_ACK);
    assign WB_DAT_OUT = cur.rdata;

    // Converter channel feeds the positive input only with the converter off.
    assign POS_FROM_MUX_OUT = cur.conv_b[`CCL_CB_MUX_EN] & ~cur.conv_en;
    // Codes above the last channel are forwarded as-is; software avoids them.
    assign POS_CHANNEL_OUT = cur.chan;
    assign NEG_FROM_IREF_OUT = cur.ctrl[`CCL_CS_IREF];
    // Division code passes straight through: 00 full, 01 half, 10 quarter, 11 eighth.
    assign IREF_DIVIDE_OUT = cur.conv_b[`CCL_CB_DIV_HI:`CCL_CB_DIV_LO];
    assign IREF_VALID_OUT = cur.ctrl[`CCL_CS_IREF]
        & (cur.ref_sel == `CCL_REFSEL_INTERNAL);
    assign CMP_POWER_OFF_OUT = cur.ctrl[`CCL_CS_DISABLE];
    // No path exists to the capture logic while routing is off.
    assign CAPTURE_ROUTE_OUT = cur.ctrl[`CCL_CS_CAPTURE];
    assign CAPTURE_SRC_OUT = cmp_sync & cur.ctrl[`CCL_CS_CAPTURE];
    assign POS_BUF_OFF_OUT = cur.din_dis[`CCL_DIS_POS];
    assign NEG_BUF_OFF_OUT = cur.din_dis[`CCL_DIS_NEG];
    assign POS_PIN_READ_OUT = pos_sync & ~cur.din_dis[`CCL_DIS_POS];
    assign NEG_PIN_READ_OUT = neg_sync & ~cur.din_dis[`CCL_DIS_NEG];
    // Clearing the enable blocks the request at once.
    assign IRQ_OUT = cur.flag & cur.ctrl[`CCL_CS_IRQ_EN] & GLOBAL_IRQ_EN_IN;
endmodule : ccl_top

// ### verification/ccl_top_properties.sv
// Concurrent checks on the ports of the comparator control block.
`timescale 1ns/100ps
module ccl_top_properties #(
    parameter int CHAN_W = 5
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic WB_ACK_OUT,
    input wire logic CMP_RAW_IN,
    input wire logic GLOBAL_IRQ_EN_IN,
    input wire logic CMP_POWER_OFF_OUT,
    input wire logic POS_FROM_MUX_OUT,
    input wire logic NEG_FROM_IREF_OUT,
    input wire logic IREF_VALID_OUT,
    input wire logic CAPTURE_SRC_OUT,
    input wire logic CAPTURE_ROUTE_OUT,
    input wire logic POS_BUF_OFF_OUT,
    input wire logic NEG_BUF_OFF_OUT,
    input wire logic POS_PIN_READ_OUT,
    input wire logic NEG_PIN_READ_OUT,
    input wire logic IRQ_OUT
);
    // ------------------------------------------------------------------------
    // Bus steps and register effects
    // ------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    // A request is taken only while the slave is idle.
    sequence wb_taken;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence

    // A write completes at the edge where ack is sampled high.
    sequence wr_done(logic [3:0] a);
        WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == a);
    endsequence

    ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
    ack_latency_a: assert property (wb_taken |=> WB_ACK_OUT) else $error("ack late");
    power_write_a: assert property (wr_done(4'h0) |=>
        CMP_POWER_OFF_OUT == $past(WB_DAT_IN[7])) else $error("power bit wrong");
    iref_write_a: assert property (wr_done(4'h0) |=>
        NEG_FROM_IREF_OUT == $past(WB_DAT_IN[6])) else $error("iref select wrong");
    conv_on_pin_a: assert property (wr_done(4'hC) ##0 WB_DAT_IN[7] |=>
        !POS_FROM_MUX_OUT) else $error("mux used while converter on");
    capture_gate_a: assert property (!CAPTURE_ROUTE_OUT |-> !CAPTURE_SRC_OUT)
        else $error("capture path open");
    sync_delay_a: assert property ((CAPTURE_ROUTE_OUT && !CMP_POWER_OFF_OUT &&
        $stable(CMP_RAW_IN)) [*3] |-> CAPTURE_SRC_OUT == CMP_RAW_IN) else $error("sync slow");
    irq_gate_a: assert property (IRQ_OUT |-> GLOBAL_IRQ_EN_IN) else $error("irq ungated");
    pin_read_off_a: assert property (!(POS_BUF_OFF_OUT && POS_PIN_READ_OUT) &&
        !(NEG_BUF_OFF_OUT && NEG_PIN_READ_OUT)) else $error("disabled pin reads one");
    iref_valid_a: assert property (IREF_VALID_OUT |-> NEG_FROM_IREF_OUT)
        else $error("reference valid without select");
endmodule : ccl_top_properties

bind ccl_top ccl_top_properties #(.CHAN_W(CHAN_W)) u_ccl_top_properties (.SYS_CLK_IN, .RST_IN,
    .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_ACK_OUT,
    .CMP_RAW_IN, .GLOBAL_IRQ_EN_IN, .CMP_POWER_OFF_OUT, .POS_FROM_MUX_OUT, .NEG_FROM_IREF_OUT,
    .IREF_VALID_OUT, .CAPTURE_SRC_OUT, .CAPTURE_ROUTE_OUT, .POS_BUF_OFF_OUT, .NEG_BUF_OFF_OUT,
    .POS_PIN_READ_OUT, .NEG_PIN_READ_OUT, .IRQ_OUT);

// ### verification/tb_ccl_top.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/100ps
`include "ccl_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_ccl_top;
    logic clk, rst, cyc, stb, we, ack, raw, pdig, ndig, gie, vec;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, got;
    logic poff, pmux, niref, ivalid, csrc, croute, pbuf, nbuf, pread, nread, irq;
    logic [4:0] pch;
    logic [1:0] idiv;
    int mismatches = 0, compares = 0, cycles = 0, i, m;

    ccl_top u_ccl_top (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .CMP_RAW_IN(raw), .POS_PIN_DIG_IN(pdig), .NEG_PIN_DIG_IN(ndig),
        .GLOBAL_IRQ_EN_IN(gie), .IRQ_VECTOR_IN(vec), .CMP_POWER_OFF_OUT(poff),
        .POS_FROM_MUX_OUT(pmux), .POS_CHANNEL_OUT(pch), .NEG_FROM_IREF_OUT(niref),
        .IREF_DIVIDE_OUT(idiv), .IREF_VALID_OUT(ivalid), .CAPTURE_SRC_OUT(csrc),
        .CAPTURE_ROUTE_OUT(croute), .POS_BUF_OFF_OUT(pbuf), .NEG_BUF_OFF_OUT(nbuf),
        .POS_PIN_READ_OUT(pread), .NEG_PIN_READ_OUT(nread), .IRQ_OUT(irq));

    // ------------------------------------------------------------------------
    // Clock, hang guard and bus tasks
    // ------------------------------------------------------------------------
    // The 25 ns clock runs from time zero.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The run needs well under a thousand cycles, so a hang is cut at 3000.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
        input logic [7:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        got = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb_xfer

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb_xfer(1'b1, a, 4'h1, d);
    endtask : wr

    // Upper bytes must read zero, so the whole word is compared.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        wb_xfer(1'b0, a, 4'hF, 8'h00);
        `CHK("read", {24'h00_0000, e}, got)
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    // Each group sets a mode through the registers and checks pins or reads.
    initial begin
        {rst, cyc, stb, we, raw, pdig, ndig, gie, vec} = 9'h001 << 8;
        adr = 4'h0; sel = 4'h0; wdat = 32'h0000_0000;
        tick(2);
        rst <= 1'b0;
        tick(1);
        rd(`CCL_ADR_CTRL_STATUS, 8'h00);
        rd(`CCL_ADR_CONV_B, 8'h00);
        rd(`CCL_ADR_DIN_DIS, 8'h00);
        wr(`CCL_ADR_CTRL_STATUS, 8'hC4);
        `CHK("power_off", 1'b1, poff)
        `CHK("neg_iref", 1'b1, niref)
        rd(`CCL_ADR_CTRL_STATUS, 8'hC4);
        wb_xfer(1'b1, `CCL_ADR_CTRL_STATUS, 4'hE, 8'h00);
        `CHK("power_off", 1'b1, poff)
        wr(`CCL_ADR_CTRL_STATUS, 8'h04);
        `CHK("capture_route", 1'b1, croute)
        `CHK("power_off", 1'b0, poff)
        `CHK("neg_iref", 1'b0, niref)
        raw <= 1'b1;
        tick(4);
        `CHK("capture_src", 1'b1, csrc)
        rd(`CCL_ADR_CTRL_STATUS, 8'h34);
        wr(`CCL_ADR_CTRL_STATUS, 8'h10);
        `CHK("capture_src", 1'b0, csrc)
        raw <= 1'b0;
        wr(`CCL_ADR_CONV_B, 8'h40);
        for (i = 0; i <= 10; i++) begin
            wr(`CCL_ADR_CONV_SIDE, 8'(i));
            `CHK("pos_mux", 1'b1, pmux)
            `CHK("channel", 5'(i), pch)
        end
        wr(`CCL_ADR_CONV_SIDE, 8'h65);
        `CHK("pos_mux", 1'b1, pmux)
        wr(`CCL_ADR_CONV_SIDE, 8'hE5);
        `CHK("pos_mux", 1'b0, pmux)
        wr(`CCL_ADR_CONV_SIDE, 8'h60);
        wr(`CCL_ADR_CTRL_STATUS, 8'h40);
        for (i = 0; i < 4; i++) begin
            wr(`CCL_ADR_CONV_B, 8'(i * 16));
            `CHK("divide", 2'(i), idiv)
            `CHK("iref_valid", 1'b1, ivalid)
            `CHK("pos_mux", 1'b0, pmux)
        end
        wr(`CCL_ADR_CONV_SIDE, 8'h20);
        `CHK("iref_valid", 1'b0, ivalid)
        wr(`CCL_ADR_CONV_B, 8'h08);
        rd(`CCL_ADR_CONV_B, 8'h00);
        pdig <= 1'b1;
        ndig <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(`CCL_ADR_DIN_DIS, 8'(i * 64));
            tick(3);
            `CHK("pin_reads", {~i[1], ~i[0]}, {pread, nread})
            `CHK("buf_off", i[1:0], {pbuf, nbuf})
        end
        // Every interrupt mode sees one rising and one falling output edge.
        for (m = 0; m < 4; m++) begin
            wr(`CCL_ADR_CTRL_STATUS, 8'h10 | 8'(m));
            raw <= 1'b1;
            tick(4);
            rd(`CCL_ADR_CTRL_STATUS, 8'h20 | 8'(m) | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
            wr(`CCL_ADR_CTRL_STATUS, 8'h10 | 8'(m));
            raw <= 1'b0;
            tick(4);
            rd(`CCL_ADR_CTRL_STATUS, 8'(m) | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
        end
        gie <= 1'b1;
        wr(`CCL_ADR_CTRL_STATUS, 8'h10);
        wr(`CCL_ADR_CTRL_STATUS, 8'h08);
        raw <= 1'b1;
        tick(4);
        `CHK("irq", 1'b1, irq)
        gie <= 1'b0;
        tick(1);
        `CHK("irq", 1'b0, irq)
        gie <= 1'b1;
        vec <= 1'b1;
        tick(1);
        vec <= 1'b0;
        tick(1);
        `CHK("irq", 1'b0, irq)
        raw <= 1'b0;
        tick(4);
        `CHK("irq", 1'b1, irq)
        wr(`CCL_ADR_CTRL_STATUS, 8'h08);
        `CHK("irq", 1'b1, irq)
        wr(`CCL_ADR_CTRL_STATUS, 8'h18);
        `CHK("irq", 1'b0, irq)
        raw <= 1'b1;
        tick(4);
        wr(`CCL_ADR_CTRL_STATUS, 8'h00);
        `CHK("irq", 1'b0, irq)
        rd(`CCL_ADR_CTRL_STATUS, 8'h30);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        tally_and_finish();
    end
endmodule : tb_ccl_top
